/* File: pkg/fault_record_pkg.sv */
// fault_record_pkg: record layout, sweep and timing constants for the fault record capture block
// assumes a 40 MHz system clock and a 26-step adc sweep numbered 0..25
package fault_record_pkg;
  localparam int unsigned clk_hz = 40000000;
  localparam int unsigned tick_us = 200;
  localparam int unsigned tick_cycles = (clk_hz / 1000000) * tick_us;
  localparam logic [12:0] tick_last = 13'(tick_cycles - 1);
  localparam logic [7:0] record_len = 8'h93;
  localparam logic [7:0] record_last = 8'h92;
  localparam int unsigned page_count = 6;
  localparam logic [4:0] sweep_last = 5'h19;
  localparam logic [7:0] pos_fault_code = 8'h00;
  localparam logic [7:0] pos_stamp0 = 8'h01;
  localparam logic [7:0] pos_int_temp_hi = 8'h15;
  localparam logic [7:0] pos_int_temp_lo = 8'h16;
  localparam logic [7:0] pos_ext_peak_hi = 8'h17;
  localparam logic [7:0] pos_ext_peak_lo = 8'h18;
  localparam logic [7:0] pos_page0 = 8'h1B;
  localparam logic [7:0] page_len = 8'h14;
  // offsets inside one event page
  localparam logic [4:0] pg_vout = 5'h00;
  localparam logic [4:0] pg_iout = 5'h04;
  localparam logic [4:0] pg_iin_chan = 5'h06;
  localparam logic [4:0] pg_vin = 5'h08;
  localparam logic [4:0] pg_iin = 5'h0A;
  localparam logic [4:0] pg_status_vout = 5'h0C;
  localparam logic [15:0] ext_peak_reset = 16'h8000;
  localparam logic [7:0] reserved_byte = 8'h00;
endpackage : fault_record_pkg

/* File: rtl/uptime_counter.sv */
// uptime_counter: 48-bit timestamp in 200 us steps since reset
// assumes ref_clk at the package clock rate
`timescale 1ns/100ps
module uptime_counter (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  output logic [47:0] uptime_timestamp // time since reset
);
  import fault_record_pkg::*;
  logic [12:0] div_q, div_d;
  logic [47:0] cnt_q, cnt_d;
  always_comb begin
    div_d = (div_q == tick_last) ? 13'h0000 : div_q + 13'h0001;
    cnt_d = (div_q == tick_last) ? cnt_q + 48'h0000_0000_0001 : cnt_q;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 13'h0000;
      cnt_q <= 48'h0000_0000_0000;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
    end
  end
  assign uptime_timestamp = cnt_q;
endmodule : uptime_counter

/* File: rtl/fault_record_capture.sv */
// fault_record_capture: builds the 147-byte fault record, finishes the adc sweep, then streams it to nvm
// assumes telemetry, sweep step and fault inputs come from logic on ref_clk; nvm writes accept on ready
// Operation
// - internal temperature of the last event goes to bytes 21 high, 22 low
// - peak external temperature since peak clear goes to bytes 23 high, 24 low
// - newest event page is filled with telemetry current at the sweep_done of sweep step 25
// - an event page holds the adc sweep running at the fault; a fault in the cycle of the step 25 sweep_done takes the next sweep
// - after a fault, conversion continues through sweep step 25 before storing
// - header and all six pages are then written to nvm as one record
// - read block length is 147, zero when nothing captured
// - byte 0 holds the code of the triggering fault
// - 48-bit 200 us timestamp copied to bytes 1 to 6, low byte first
`timescale 1ns/100ps
module fault_record_capture (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic fault_trigger, // one-cycle fault pulse
  input wire logic [7:0] fault_code, // source of fault, valid with trigger
  input wire logic [4:0] sweep_step, // adc sweep step being converted
  input wire logic sweep_done, // pulse: conversion of sweep_step finished
  input wire logic [15:0] vout_value, // output voltage, linear16
  input wire logic [15:0] iout_value, // output current, linear11
  input wire logic [15:0] channel_input_current, // channel input current
  input wire logic [15:0] vin_value, // input voltage
  input wire logic [15:0] iin_value, // input current
  input wire logic [7:0] status_vout, // output status byte
  input wire logic [15:0] int_temp, // internal temperature, linear11
  input wire logic [15:0] ext_temp, // external temperature, linear11
  input wire logic peak_clear_command, // pulse: restart peak tracking
  input wire logic [7:0] read_addr, // fault_record_read byte index
  output logic [7:0] read_data, // byte at read_addr
  output logic [7:0] read_length, // block length reported
  output logic nvm_wr_valid, // nvm write request
  input wire logic nvm_wr_ready, // nvm accepts write
  output logic [7:0] nvm_wr_addr, // record byte index
  output logic [7:0] nvm_wr_data, // record byte
  output logic busy // capture or store under way
);
  import fault_record_pkg::*;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_sweep = 2'b01,
    st_store = 2'b10
  } state_type;
  // the spare code 2'b11 is never entered; the case default returns it to idle
  state_type state_q, state_d;
  logic [47:0] uptime_timestamp;
  logic [7:0] mem_q [0:146];
  logic [7:0] mem_d [0:146];
  logic [7:0] code_q, code_d;
  logic [47:0] stamp_q, stamp_d;
  logic [15:0] peak_q, peak_d;
  logic [7:0] ptr_q, ptr_d;
  logic valid_q, valid_d;
  logic [7:0] rd_q, rd_d;
  logic [7:0] wdat_q, wdat_d;

  // the timestamp runs free from reset; only its value at the accepted trigger is kept
  uptime_counter u_uptime (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .uptime_timestamp(uptime_timestamp)
  );

  // compare linear11 values exactly: the exponent is offset by 16 so every shift is to the left
  // and no mantissa bit is lost, as a right shift of a small mantissa would lose it
  function automatic logic signed [47:0] lin11_mag(input logic [15:0] v);
    logic [4:0] sh;
    logic signed [47:0] m;
    sh = {~v[15], v[14:11]};
    m = 48'(signed'(v[10:0]));
    lin11_mag = m <<< sh;
  endfunction : lin11_mag

  // positions that read zero whatever an earlier record left in them
  function automatic logic is_reserved(input int idx);
    is_reserved = (idx == 19) || (idx == 20) || (idx == 25) || (idx == 26) ||
      (idx == 29) || (idx == 30) || (idx == 40);
  endfunction : is_reserved

  // the peak tracker runs in every state, so a capture records the maximum seen before its edge
  always_comb begin
    peak_d = peak_q;
    if (peak_clear_command) begin
      peak_d = ext_peak_reset;
    end else if (peak_q == ext_peak_reset || lin11_mag(ext_temp) > lin11_mag(peak_q)) begin
      peak_d = ext_temp;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      peak_q <= ext_peak_reset;
    end else begin
      peak_q <= peak_d;
    end
  end

  // fault identity and time are latched only at an accepted trigger, so later triggers cannot disturb them
  always_comb begin
    code_d = code_q;
    stamp_d = stamp_q;
    if (state_q == st_idle && fault_trigger) begin
      code_d = fault_code;
      stamp_d = uptime_timestamp;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      code_q <= 8'h00;
      stamp_q <= 48'h0000_0000_0000;
    end else begin
      code_q <= code_d;
      stamp_q <= stamp_d;
    end
  end

  // older pages are never written and keep their reset zeros; only the newest page is rebuilt here
  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    valid_d = valid_q;
    for (int i = 0; i < 147; i++) begin
      mem_d[i] = mem_q[i];
    end
    unique case (state_q)
      st_idle: begin
        // a trigger outside idle is dropped: one record per capture
        if (fault_trigger) begin
          state_d = st_sweep;
        end
      end
      st_sweep: begin
        // each finished step of the running sweep updates the newest page
        if (sweep_done) begin
          mem_d[pos_page0 + 8'(pg_vout)] = vout_value[15:8];
          mem_d[pos_page0 + 8'(pg_vout) + 8'h01] = vout_value[7:0];
          mem_d[pos_page0 + 8'(pg_iout)] = iout_value[15:8];
          mem_d[pos_page0 + 8'(pg_iout) + 8'h01] = iout_value[7:0];
          mem_d[pos_page0 + 8'(pg_iin_chan)] = channel_input_current[15:8];
          mem_d[pos_page0 + 8'(pg_iin_chan) + 8'h01] = channel_input_current[7:0];
          mem_d[pos_page0 + 8'(pg_vin)] = vin_value[15:8];
          mem_d[pos_page0 + 8'(pg_vin) + 8'h01] = vin_value[7:0];
          mem_d[pos_page0 + 8'(pg_iin)] = iin_value[15:8];
          mem_d[pos_page0 + 8'(pg_iin) + 8'h01] = iin_value[7:0];
          mem_d[pos_page0 + 8'(pg_status_vout)] = status_vout;
          if (sweep_step == sweep_last) begin
            mem_d[pos_fault_code] = code_q;
            for (int b = 0; b < 6; b++) begin
              mem_d[pos_stamp0 + 8'(b)] = stamp_q[8*b +: 8];
            end
            mem_d[pos_int_temp_hi] = int_temp[15:8];
            mem_d[pos_int_temp_lo] = int_temp[7:0];
            mem_d[pos_ext_peak_hi] = peak_q[15:8];
            mem_d[pos_ext_peak_lo] = peak_q[7:0];
            ptr_d = 8'h00;
            state_d = st_store;
          end
        end
      end
      st_store: begin
        // ready low holds index and byte in place; there is no timeout, nvm must answer
        if (nvm_wr_ready) begin
          if (ptr_q == record_last) begin
            valid_d = 1'b1;
            state_d = st_idle;
          end else begin
            ptr_d = ptr_q + 8'h01;
          end
        end
      end
      default: state_d = st_idle;
    endcase
    // reserved positions forced to zero
    for (int r = 0; r < 147; r++) begin
      if (is_reserved(r)) begin
        mem_d[r] = reserved_byte;
      end
    end
  end

  // host and nvm bytes come from flip-flops; the nvm byte is launched together with its index
  always_comb begin
    rd_d = (read_addr <= record_last) ? mem_q[read_addr] : reserved_byte;
    wdat_d = (state_d == st_store) ? mem_d[ptr_d] : reserved_byte;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= 8'h00;
      wdat_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
      wdat_q <= wdat_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= st_idle;
      ptr_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      valid_q <= valid_d;
    end
  end

  // record bytes have their own register group so the control registers above stay small
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 147; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 147; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign read_data = rd_q;
  assign read_length = valid_q ? record_len : 8'h00;
  assign nvm_wr_valid = (state_q == st_store);
  assign nvm_wr_addr = ptr_q;
  assign nvm_wr_data = wdat_q;
  assign busy = (state_q != st_idle);
endmodule : fault_record_capture

/* File: testbench/record_chk.sv */
// record_chk: port timing checks for capture, store and readback
// assumes bind onto fault_record_capture, one clock domain
`timescale 1ns/100ps
module record_chk (
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic fault_trigger, // fault pulse
  input wire logic [4:0] sweep_step, // sweep step
  input wire logic sweep_done, // step done
  input wire logic [7:0] read_addr, // read index
  input wire logic [7:0] read_data, // read byte
  input wire logic [7:0] read_length, // block length
  input wire logic nvm_wr_valid, // write request
  input wire logic nvm_wr_ready, // write accept
  input wire logic [7:0] nvm_wr_addr, // write index
  input wire logic [7:0] nvm_wr_data, // write byte
  input wire logic busy // capture busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_acc; nvm_wr_valid && nvm_wr_ready; endsequence
  sequence s_end; busy && !nvm_wr_valid && sweep_done && sweep_step == 5'h19; endsequence
  property p_take; fault_trigger && !busy |=> busy; endproperty
  property p_wait; busy && !nvm_wr_valid && !(sweep_done && sweep_step == 5'h19) |=> !nvm_wr_valid; endproperty
  property p_start; s_end |=> nvm_wr_valid && nvm_wr_addr == 8'h00; endproperty
  property p_hold; nvm_wr_valid && !nvm_wr_ready |=> nvm_wr_valid && $stable(nvm_wr_addr) && $stable(nvm_wr_data);
  endproperty
  property p_step; s_acc ##0 (nvm_wr_addr != 8'h92) |=> nvm_wr_addr == $past(nvm_wr_addr) + 8'h01; endproperty
  property p_last; s_acc ##0 (nvm_wr_addr == 8'h92) |=> !busy && !nvm_wr_valid && read_length == 8'h93; endproperty
  property p_len; read_length == 8'h00 || read_length == 8'h93; endproperty
  property p_resv; nvm_wr_valid && nvm_wr_addr inside {8'h14, 8'h19, 8'h1A, 8'h1D, 8'h1E, 8'h28} |-> nvm_wr_data == 8'h00;
  endproperty
  property p_oob; read_addr > 8'h92 |=> read_data == 8'h00; endproperty
  a_take: assert property (p_take) else $error("no busy after trigger");
  a_wait: assert property (p_wait) else $error("store before sweep end");
  a_start: assert property (p_start) else $error("store not started");
  a_hold: assert property (p_hold) else $error("write dropped while stalled");
  a_step: assert property (p_step) else $error("write index skipped");
  a_last: assert property (p_last) else $error("store end wrong");
  a_len: assert property (p_len) else $error("bad block length");
  a_resv: assert property (p_resv) else $error("reserved byte nonzero");
  a_oob: assert property (p_oob) else $error("read past record nonzero");
endmodule : record_chk
bind fault_record_capture record_chk chk_u (
  .ref_clk(ref_clk), .rstn(rstn), .fault_trigger(fault_trigger), .sweep_step(sweep_step),
  .sweep_done(sweep_done), .read_addr(read_addr), .read_data(read_data), .read_length(read_length),
  .nvm_wr_valid(nvm_wr_valid), .nvm_wr_ready(nvm_wr_ready), .nvm_wr_addr(nvm_wr_addr),
  .nvm_wr_data(nvm_wr_data), .busy(busy)
);

/* File: testbench/nvm_model.sv */
// nvm_model: record store memory that stalls every fourth cycle
// assumes writes of bytes 0..146 only
`timescale 1ns/100ps
module nvm_model (
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic nvm_wr_valid, // write request
  input wire logic [7:0] nvm_wr_addr, // byte index
  input wire logic [7:0] nvm_wr_data, // byte
  output logic nvm_wr_ready // accept
);
  logic [7:0] mem [0:146];
  logic [1:0] stall_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) stall_q <= 2'h0;
    else begin
      stall_q <= stall_q + 2'h1;
      if (nvm_wr_valid && nvm_wr_ready) mem[nvm_wr_addr] <= nvm_wr_data;
    end
  end
  // periodic stall exercises the hold path of the writer
  assign nvm_wr_ready = (stall_q != 2'h3);
endmodule : nvm_model

/* File: testbench/testbench.sv */
// testbench: random captures with stalled stores, then full readback
// assumes fault_record_capture and nvm_model on one 40 MHz clock
`timescale 1ns/100ps
module testbench;
  logic ref_clk, rstn, fault_trigger, sweep_done, peak_clear_command, busy, nvm_wr_valid, nvm_wr_ready;
  logic [7:0] fault_code, status_vout, read_addr, read_data, read_length, nvm_wr_addr, nvm_wr_data;
  logic [4:0] sweep_step;
  logic [15:0] vout_value, iout_value, channel_input_current, vin_value, iin_value, int_temp, ext_temp, peak;
  logic [7:0] rec [0:40];
  logic [47:0] ts;
  int seed = 52, n_errors = 0, comparisons = 0, cyc = 0, s;
  fault_record_capture dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .fault_trigger(fault_trigger), .fault_code(fault_code),
    .sweep_step(sweep_step), .sweep_done(sweep_done), .vout_value(vout_value), .iout_value(iout_value),
    .channel_input_current(channel_input_current), .vin_value(vin_value), .iin_value(iin_value),
    .status_vout(status_vout), .int_temp(int_temp), .ext_temp(ext_temp),
    .peak_clear_command(peak_clear_command), .read_addr(read_addr), .read_data(read_data),
    .read_length(read_length), .nvm_wr_valid(nvm_wr_valid), .nvm_wr_ready(nvm_wr_ready),
    .nvm_wr_addr(nvm_wr_addr), .nvm_wr_data(nvm_wr_data), .busy(busy)
  );
  nvm_model nvm_u (
    .ref_clk(ref_clk), .rstn(rstn), .nvm_wr_valid(nvm_wr_valid), .nvm_wr_addr(nvm_wr_addr),
    .nvm_wr_data(nvm_wr_data), .nvm_wr_ready(nvm_wr_ready)
  );
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (rstn) cyc++;
  function automatic real lin11(input logic [15:0] v);
    return $itor($signed(v[10:0])) * (2.0 ** $signed(v[15:11]));
  endfunction : lin11
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task step(input int st);
    @(negedge ref_clk);
    {vout_value, iout_value, channel_input_current, vin_value, iin_value} = 80'({$random(seed), $random(seed), $random(seed)});
    {status_vout, int_temp} = 24'($random(seed));
    // the recorded peak holds readings sampled before the capturing edge, so fold in the old one first
    if (lin11(ext_temp) > lin11(peak)) peak = ext_temp;
    ext_temp = {5'($random(seed) % 3), 11'($random(seed))};
    sweep_step = 5'(st);
    sweep_done = 1;
    @(negedge ref_clk);
    sweep_done = 0;
  endtask : step
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    {fault_trigger, sweep_done, peak_clear_command, fault_code, sweep_step, read_addr, status_vout} = '0;
    {vout_value, iout_value, channel_input_current, vin_value, iin_value, int_temp, ext_temp} = '0;
    rstn = 0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) rstn = 1;
    @(negedge ref_clk) check(read_length, 8'h00);
    for (int r = 0; r < 3; r++) begin
      peak_clear_command = 1;
      @(negedge ref_clk) peak_clear_command = 0;
      peak = ext_temp;
      // trigger mid-tick so the stamp is unambiguous
      while (cyc % 8000 != 4000) @(negedge ref_clk);
      s = (r == 0) ? 25 : (r == 1) ? 0 : {$random(seed)} % 26;
      ts = 48'(cyc / 8000);
      fault_code = 8'($random(seed));
      rec = '{default: 8'h00};
      rec[0] = fault_code;
      fault_trigger = 1;
      @(negedge ref_clk) fault_trigger = 0;
      fault_code = ~fault_code;
      for (int st = s; st < 26; st++) begin
        step(st);
        if (st == s) begin
          fault_trigger = 1;
          @(negedge ref_clk) fault_trigger = 0;
        end
      end
      for (int i = 0; i < 6; i++) rec[1 + i] = ts[8 * i +: 8];
      {rec[21], rec[22], rec[23], rec[24]} = {int_temp, peak};
      {rec[27], rec[28], rec[31], rec[32], rec[33], rec[34]} = {vout_value, iout_value, channel_input_current};
      {rec[35], rec[36], rec[37], rec[38], rec[39]} = {vin_value, iin_value, status_vout};
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge ref_clk);
      check(busy, 1'b0);
      check(read_length, 8'h93);
      for (int a = 0; a < 148; a++) begin
        read_addr = (a == 147) ? 8'hC8 : 8'(a);
        @(negedge ref_clk);
        if (a < 41 && !(a inside {[7:18]})) check(read_data, rec[a]);
        check(read_data, (a < 147) ? nvm_u.mem[a] : 8'h00);
      end
    end
    tally_and_finish;
  end
endmodule : testbench
